// ===== clc_capture.sv
// capture control top: apb registers, link-side capture, roi, padding and byte swap
`timescale 1ns/1ps
`include "clc_defines.svh"
module clc_capture import clc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`CLC_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cl_clk,
  input wire logic cl_lval,
  input wire logic cl_fval,
  input wire logic cl_dval,
  input wire logic [`CLC_PW-1:0] cl_data,
  output logic pix_valid,
  output logic [`CLC_PW-1:0] pix_data,
  output logic pix_eol,
  output logic pix_eof,
  output logic frame_valid
);
  // active pixel bits from the data path word, colour overrides it
  function automatic logic [`CLC_PW-1:0] path_mask(input logic [7:0] path, input logic color);
    int bits;
    bits = (int'(path[`CLC_TAPS_HI:`CLC_TAPS_LO]) + 1) * (int'(path[`CLC_BPP_HI:`CLC_BPP_LO]) + 1);
    if (color || bits >= `CLC_PW) begin
      path_mask = '1;
    end else begin
      path_mask = `CLC_PW'((`CLC_PW+1)'(1) << bits) - `CLC_PW'(1);
    end
  endfunction

  function automatic logic [`CLC_PW-1:0] swap_bytes(input logic [`CLC_PW-1:0] w);
    swap_bytes = {w[7:0], w[15:8], w[23:16]};
  endfunction

  // ---------------- apb side ----------------
  logic [7:0] util_q, link_q, path_q;
  logic [`CLC_CW-1:0] hskip_q, hactv_q, vskip_q, vactv_q;
  logic [31:0] stat_p;
  logic [`CLC_IW-1:0] idx;
  logic hit, wr_en, rd_setup;
  clc_cfg_t cfg_src, cfg;

  assign idx = paddr[`CLC_AW-1:2];
  // decode of mapped indices
  always_comb begin
    unique case (idx)
      `CLC_IDX_UTIL, `CLC_IDX_PATH, `CLC_IDX_LINK, `CLC_IDX_HSKIP, `CLC_IDX_HACTV,
      `CLC_IDX_VSKIP, `CLC_IDX_VACTV, `CLC_IDX_STAT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pready = 1'b1; // zero-wait slave
  assign pslverr = psel & penable & ~hit;
  assign wr_en = psel & penable & pwrite & hit;
  assign rd_setup = psel & ~penable & ~pwrite;

  // register writes; reserved bit 6 never stores
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      util_q <= `CLC_UTIL_INIT;
      link_q <= `CLC_LINK_INIT;
      path_q <= `CLC_PATH_INIT;
      hskip_q <= `CLC_CNT_ZERO;
      hactv_q <= `CLC_CNT_ZERO;
      vskip_q <= `CLC_CNT_ZERO;
      vactv_q <= `CLC_CNT_ZERO;
    end else if (wr_en) begin
      unique case (idx)
        `CLC_IDX_UTIL: util_q <= pwdata[7:0];
        `CLC_IDX_LINK: link_q <= pwdata[7:0] & `CLC_LINK_WMASK;
        `CLC_IDX_PATH: path_q <= pwdata[7:0];
        `CLC_IDX_HSKIP: hskip_q <= pwdata[`CLC_CW-1:0];
        `CLC_IDX_HACTV: hactv_q <= pwdata[`CLC_CW-1:0];
        `CLC_IDX_VSKIP: vskip_q <= pwdata[`CLC_CW-1:0];
        `CLC_IDX_VACTV: vactv_q <= pwdata[`CLC_CW-1:0];
        default: ;
      endcase
    end
  end

  // read data registered in the setup cycle, valid through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (idx)
        `CLC_IDX_UTIL: prdata <= {24'h00_0000, util_q};
        `CLC_IDX_LINK: prdata <= {24'h00_0000, link_q};
        `CLC_IDX_PATH: prdata <= {24'h00_0000, path_q};
        `CLC_IDX_HSKIP: prdata <= {16'h0000, hskip_q};
        `CLC_IDX_HACTV: prdata <= {16'h0000, hactv_q};
        `CLC_IDX_VSKIP: prdata <= {16'h0000, vskip_q};
        `CLC_IDX_VACTV: prdata <= {16'h0000, vactv_q};
        `CLC_IDX_STAT: prdata <= stat_p;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // whole setting crosses as one word so bits written together land together
  assign cfg_src = '{link: link_q, path: path_q, byte_swap_enable: util_q[`CLC_BIT_BYTE_SWAP_ENABLE],
                     hskip: hskip_q, hactv: hactv_q, vskip: vskip_q, vactv: vactv_q};

  // ---------------- link side reset ----------------
  logic [1:0] cl_rst_q;
  logic cl_rst_n;
  // asserts at once, releases on the pixel clock
  always_ff @(posedge cl_clk or negedge presetn) begin
    if (!presetn) begin
      cl_rst_q <= 2'b00;
    end else begin
      cl_rst_q <= {cl_rst_q[0], 1'b1};
    end
  end
  assign cl_rst_n = cl_rst_q[1];

  logic [31:0] stat_c;
  clc_word_cdc #(.W($bits(clc_cfg_t))) u_cfg_cdc (
    .src_clk(pclk),
    .src_rst_n(presetn),
    .src_data(cfg_src),
    .dst_clk(cl_clk),
    .dst_rst_n(cl_rst_n),
    .dst_data(cfg)
  );
  clc_word_cdc #(.W(32)) u_stat_cdc (
    .src_clk(cl_clk),
    .src_rst_n(cl_rst_n),
    .src_data(stat_c),
    .dst_clk(pclk),
    .dst_rst_n(presetn),
    .dst_data(stat_p)
  );

  // ---------------- link side capture ----------------
  logic pad_en, cnt_dis, lv_sub, fgen, no_dv, dv_inv, color;
  logic lv_q, fv_q, dv_q, lv_p, fv_p, fv_act, line_end, frame_end, cam_pix;
  logic [`CLC_PW-1:0] data_q, cam_word;
  logic [`CLC_CW-1:0] hcnt_q, vcnt_q, pad_cnt_q, pad_lines_q;
  logic eof_pend_q;
  clc_pad_state_t st_q;
  clc_win_if w ();

  assign pad_en = cfg.link[`CLC_BIT_PAD];
  assign cnt_dis = cfg.link[`CLC_BIT_CNTDIS];
  assign lv_sub = cfg.link[`CLC_BIT_LVSUB];
  assign fgen = cfg.link[`CLC_BIT_FGEN];
  assign no_dv = cfg.link[`CLC_BIT_NODV];
  assign dv_inv = cfg.link[`CLC_BIT_DVINV];
  assign color = cfg.link[`CLC_BIT_COLOR];

  // camera pins live on their own clock, one sampling stage suffices
  always_ff @(posedge cl_clk or negedge cl_rst_n) begin
    if (!cl_rst_n) begin
      lv_q <= 1'b0;
      fv_q <= 1'b0;
      dv_q <= 1'b0;
      data_q <= '0;
      lv_p <= 1'b0;
      fv_p <= 1'b0;
    end else begin
      lv_q <= cl_lval;
      fv_q <= lv_sub ? cl_lval : cl_fval;
      dv_q <= no_dv ? 1'b1 : (cl_dval ^ dv_inv);
      data_q <= cl_data;
      lv_p <= lv_q;
      fv_p <= fv_q;
    end
  end

  assign fv_act = fgen | fv_q;
  assign line_end = lv_p & ~lv_q;
  // generated frames end on the vactv-th line, otherwise on the falling frame signal
  assign frame_end = fgen ? (line_end && (vcnt_q + `CLC_CNT_ONE >= cfg.vactv) && (cfg.vactv != `CLC_CNT_ZERO))
                          : (fv_p & ~fv_q);
  assign cam_pix = (st_q == CLC_IDLE) & lv_q & dv_q & fv_act & w.h_in & w.v_in;
  assign cam_word = data_q & path_mask(cfg.path, color);

  assign w.hcnt = hcnt_q;
  assign w.vcnt = vcnt_q;
  assign w.hskip = cfg.hskip;
  assign w.hactv = cfg.hactv;
  assign w.vskip = cfg.vskip;
  assign w.vactv = cfg.vactv;
  assign w.cnt_dis = cnt_dis;
  assign w.pad_en = pad_en;
  clc_roi_win u_win (
    .w(w.win)
  );

  // pixel and line counters, counted on the pixel clock
  always_ff @(posedge cl_clk or negedge cl_rst_n) begin
    if (!cl_rst_n) begin
      hcnt_q <= `CLC_CNT_ZERO;
      vcnt_q <= `CLC_CNT_ZERO;
    end else begin
      if (line_end) begin
        hcnt_q <= `CLC_CNT_ZERO;
      end else if (lv_q && dv_q && fv_act && hcnt_q != `CLC_CNT_MAX) begin
        hcnt_q <= hcnt_q + `CLC_CNT_ONE;
      end
      if (frame_end) begin
        vcnt_q <= `CLC_CNT_ZERO;
      end else if (line_end && fv_act && vcnt_q != `CLC_CNT_MAX) begin
        vcnt_q <= vcnt_q + `CLC_CNT_ONE;
      end
    end
  end

  // measured size of the last line and frame, readable from the host side
  always_ff @(posedge cl_clk or negedge cl_rst_n) begin
    if (!cl_rst_n) begin
      stat_c <= 32'h0000_0000;
    end else begin
      if (line_end) begin
        stat_c[15:0] <= hcnt_q;
      end
      // a frame closing on a line end has not yet counted that line
      if (frame_end) begin
        stat_c[31:16] <= line_end ? vcnt_q + `CLC_CNT_ONE : vcnt_q;
      end
    end
  end

  // padding engine; camera pixels arriving while it pads are dropped, so blanking must cover it
  always_ff @(posedge cl_clk or negedge cl_rst_n) begin
    if (!cl_rst_n) begin
      st_q <= CLC_IDLE;
      pad_cnt_q <= `CLC_CNT_ZERO;
      pad_lines_q <= `CLC_CNT_ZERO;
      eof_pend_q <= 1'b0;
    end else begin
      unique case (st_q)
        CLC_IDLE: begin
          if (frame_end && w.v_short) begin
            st_q <= CLC_PAD_LINES;
            pad_cnt_q <= cfg.hactv;
            pad_lines_q <= w.v_left;
          end else if (line_end && w.h_short && w.v_in && hcnt_q != `CLC_CNT_ZERO) begin
            st_q <= CLC_PAD_PIX;
            pad_cnt_q <= w.h_left;
            eof_pend_q <= frame_end;
          end
        end
        CLC_PAD_PIX: begin
          pad_cnt_q <= pad_cnt_q - `CLC_CNT_ONE;
          if (pad_cnt_q == `CLC_CNT_ONE) begin
            st_q <= CLC_IDLE;
            eof_pend_q <= 1'b0;
          end
        end
        CLC_PAD_LINES: begin
          if (pad_cnt_q == `CLC_CNT_ONE) begin
            pad_cnt_q <= cfg.hactv;
            pad_lines_q <= pad_lines_q - `CLC_CNT_ONE;
            if (pad_lines_q == `CLC_CNT_ONE) begin
              st_q <= CLC_IDLE;
            end
          end else begin
            pad_cnt_q <= pad_cnt_q - `CLC_CNT_ONE;
          end
        end
      endcase
    end
  end

  // output stage; padded words look like real ones, eof waits for padding to finish
  always_ff @(posedge cl_clk or negedge cl_rst_n) begin
    if (!cl_rst_n) begin
      pix_valid <= 1'b0;
      pix_data <= '0;
      pix_eol <= 1'b0;
      pix_eof <= 1'b0;
      frame_valid <= 1'b0;
    end else begin
      pix_valid <= cam_pix | (st_q != CLC_IDLE);
      if (st_q != CLC_IDLE) begin
        pix_data <= '0;
      end else begin
        pix_data <= cfg.byte_swap_enable ? swap_bytes(cam_word) : cam_word;
      end
      pix_eol <= ((st_q == CLC_IDLE) && line_end && w.v_in && !(w.h_short && hcnt_q != `CLC_CNT_ZERO))
                 || ((st_q != CLC_IDLE) && pad_cnt_q == `CLC_CNT_ONE);
      pix_eof <= ((st_q == CLC_IDLE) && frame_end && !w.v_short
                  && !(line_end && w.h_short && w.v_in && hcnt_q != `CLC_CNT_ZERO))
                 || ((st_q == CLC_PAD_PIX) && pad_cnt_q == `CLC_CNT_ONE && eof_pend_q)
                 || ((st_q == CLC_PAD_LINES) && pad_cnt_q == `CLC_CNT_ONE && pad_lines_q == `CLC_CNT_ONE);
      frame_valid <= fgen ? ~frame_end : fv_q;
    end
  end

  // ---------------- checks ----------------
  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && idx == `CLC_IDX_LINK) |-> prdata[6] == 1'b0)
    else $error("reserved link control bit read back as one");
  AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !hit) |-> pslverr && pready)
    else $error("unmapped access not flagged");
  AST_PAD_OFF: assert property (@(posedge cl_clk) disable iff (!cl_rst_n)
    (!pad_en && st_q == CLC_IDLE) |=> st_q == CLC_IDLE)
    else $error("padding started while disabled");
  AST_DV_INV: assert property (@(posedge cl_clk) disable iff (!cl_rst_n)
    (dv_inv && !no_dv && $past(cl_dval) && st_q == CLC_IDLE && $stable(cfg)) |=> !pix_valid)
    else $error("inverted data valid still accepted");
  AST_NO_DV: assert property (@(posedge cl_clk) disable iff (!cl_rst_n)
    (no_dv && lv_q && fv_act && w.h_in && w.v_in && st_q == CLC_IDLE) |=> pix_valid)
    else $error("pixel lost with data valid ignored");
  AST_CNT_DIS: assert property (@(posedge cl_clk) disable iff (!cl_rst_n)
    (cnt_dis && !pad_en) |-> (w.h_in && w.v_in))
    else $error("window applied while counters disabled");
  AST_WIDTH_ONLY: assert property (@(posedge cl_clk) disable iff (!cl_rst_n)
    (cnt_dis && pad_en) |-> (w.v_in && !w.v_short))
    else $error("height cropped in width only mode");
  AST_LV_SUB: assert property (@(posedge cl_clk) disable iff (!cl_rst_n)
    (lv_sub && !fgen && !pad_en && $fell(lv_q) && $past(lv_sub)) |=> pix_eof)
    else $error("line end did not close frame with line valid substituted");
  AST_FGEN: assert property (@(posedge cl_clk) disable iff (!cl_rst_n)
    (fgen && frame_end) |-> (vcnt_q + `CLC_CNT_ONE >= cfg.vactv) ##1 (!frame_valid && vcnt_q == `CLC_CNT_ZERO))
    else $error("generated frame ended at wrong line count");
  AST_BYTE_SWAP_ENABLE: assert property (@(posedge cl_clk) disable iff (!cl_rst_n)
    (cam_pix && cfg.byte_swap_enable && color) |=> pix_data == {$past(data_q[7:0]), $past(data_q[15:8]), $past(data_q[23:16])})
    else $error("byte order not swapped");
  AST_PATH_MASK: assert property (@(posedge cl_clk) disable iff (!cl_rst_n)
    (cam_pix && !color && !cfg.byte_swap_enable && cfg.path == 8'h07) |=> pix_data[23:8] == 16'h0000)
    else $error("data path width not applied");
  AST_PAD_LINE: assert property (@(posedge cl_clk) disable iff (!cl_rst_n)
    (st_q == CLC_PAD_PIX && pad_cnt_q == `CLC_CNT_ONE) |=> (pix_valid && pix_eol) ##1 st_q == CLC_IDLE || !pad_en)
    else $error("line padding did not close the line");
endmodule

// ===== clc_defines.svh
// register indices, field positions, reset values and widths of the capture control block
`ifndef CLC_DEFINES_SVH
`define CLC_DEFINES_SVH
`define CLC_AW 12
`define CLC_IW 10
`define CLC_CW 16
`define CLC_PW 24
`define CLC_IDX_UTIL 10'h00f
`define CLC_IDX_PATH 10'h028
`define CLC_IDX_LINK 10'h029
`define CLC_IDX_HSKIP 10'h030
`define CLC_IDX_HACTV 10'h031
`define CLC_IDX_VSKIP 10'h032
`define CLC_IDX_VACTV 10'h033
`define CLC_IDX_STAT 10'h034
`define CLC_UTIL_INIT 8'h00
`define CLC_LINK_INIT 8'h00
`define CLC_PATH_INIT 8'h07
`define CLC_LINK_WMASK 8'hbf
`define CLC_BIT_BYTE_SWAP_ENABLE 0
`define CLC_BIT_PAD 7
`define CLC_BIT_DVINV 5
`define CLC_BIT_FGEN 4
`define CLC_BIT_CNTDIS 3
`define CLC_BIT_LVSUB 2
`define CLC_BIT_NODV 1
`define CLC_BIT_COLOR 0
`define CLC_TAPS_HI 7
`define CLC_TAPS_LO 4
`define CLC_BPP_HI 3
`define CLC_BPP_LO 0
`define CLC_CNT_ZERO 16'h0000
`define CLC_CNT_ONE 16'h0001
`define CLC_CNT_MAX 16'hffff
`endif

// ===== clc_pkg.sv
// types shared by the capture control modules
package clc_pkg;
`include "clc_defines.svh"
  typedef enum logic [1:0] {CLC_IDLE, CLC_PAD_PIX, CLC_PAD_LINES} clc_pad_state_t;
  typedef struct packed {
    logic [7:0] link;
    logic [7:0] path;
    logic byte_swap_enable;
    logic [`CLC_CW-1:0] hskip;
    logic [`CLC_CW-1:0] hactv;
    logic [`CLC_CW-1:0] vskip;
    logic [`CLC_CW-1:0] vactv;
  } clc_cfg_t;
endpackage

// ===== clc_win_if.sv
// window counters and their decode between the capture logic and the window comparator
`timescale 1ns/1ps
interface clc_win_if;
  logic [15:0] hcnt, vcnt, hskip, hactv, vskip, vactv;
  logic cnt_dis, pad_en;
  logic h_in, v_in, h_short, v_short;
  logic [15:0] h_left, v_left;
  modport ctl (output hcnt, vcnt, hskip, hactv, vskip, vactv, cnt_dis, pad_en,
               input h_in, v_in, h_short, v_short, h_left, v_left);
  modport win (input hcnt, vcnt, hskip, hactv, vskip, vactv, cnt_dis, pad_en,
               output h_in, v_in, h_short, v_short, h_left, v_left);
endinterface

// ===== clc_roi_win.sv
// region-of-interest window comparator, purely combinational
`timescale 1ns/1ps
`include "clc_defines.svh"
module clc_roi_win (
  clc_win_if.win w
);
  logic [16:0] hstop, vstop;
  logic width_only;
  // stop positions kept one bit wider so a window at the top of the range cannot wrap
  always_comb begin
    hstop = {1'b0, w.hskip} + {1'b0, w.hactv};
    vstop = {1'b0, w.vskip} + {1'b0, w.vactv};
    width_only = w.cnt_dis & w.pad_en;
    if (w.cnt_dis & ~w.pad_en) begin
      w.h_in = 1'b1;
    end else begin
      w.h_in = ({1'b0, w.hcnt} >= {1'b0, w.hskip}) && ({1'b0, w.hcnt} < hstop);
    end
    w.v_in = w.cnt_dis | (({1'b0, w.vcnt} >= {1'b0, w.vskip}) && ({1'b0, w.vcnt} < vstop));
    w.h_short = w.pad_en & (w.hactv != `CLC_CNT_ZERO) & ({1'b0, w.hcnt} < hstop);
    w.v_short = w.pad_en & ~width_only & (w.vactv != `CLC_CNT_ZERO) & ({1'b0, w.vcnt} < vstop);
    w.h_left = (w.hcnt < w.hskip) ? w.hactv : 16'(hstop - {1'b0, w.hcnt});
    w.v_left = (w.vcnt < w.vskip) ? w.vactv : 16'(vstop - {1'b0, w.vcnt});
  end
endmodule

// ===== clc_word_cdc.sv
// toggle handshake that carries a word from one clock domain to another
`timescale 1ns/1ps
module clc_word_cdc #(
  parameter int W = 32
) (
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic [W-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic [W-1:0] dst_data
);
  logic [W-1:0] hold_q;
  logic req_q, ack_q;
  logic [2:0] ack_s_q, req_s_q;
  // source resamples only after the last word was acknowledged, so hold_q is stable while crossing
  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      ack_s_q <= 3'h0;
      req_q <= 1'b0;
      hold_q <= '0;
    end else begin
      ack_s_q <= {ack_s_q[1:0], ack_q};
      if ((ack_s_q[1] == ack_s_q[2]) && (ack_s_q[2] == req_q)) begin
        hold_q <= src_data;
        req_q <= ~req_q;
      end
    end
  end
  // destination takes the word once the two late sync stages agree on a new request level
  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      req_s_q <= 3'h0;
      ack_q <= 1'b0;
      dst_data <= '0;
    end else begin
      req_s_q <= {req_s_q[1:0], req_q};
      if ((req_s_q[1] == req_s_q[2]) && (req_s_q[2] != ack_q)) begin
        dst_data <= hold_q;
        ack_q <= req_s_q[2];
      end
    end
  end
endmodule

// ===== clc_cam_model.sv
// camera model driving pixel clock, line, frame and data valid and pixel taps
`timescale 1ns/1ps
module clc_cam_model (
  output logic cl_clk,
  output logic cl_lval,
  output logic cl_fval,
  output logic cl_dval,
  output logic [23:0] cl_data
);
  // quiet levels at time zero, clock parked low
  initial begin
    cl_clk = 1'b0;
    cl_lval = 1'b0;
    cl_fval = 1'b0;
    cl_dval = 1'b0;
    cl_data = 24'h5a5a5a;
  end
  // pixel pattern, nonzero in every tap so padded zeros stand out
  function automatic logic [23:0] pix(input int v, input int h);
    pix = {8'(v + 16), 8'(h + 64), 8'(h ^ v ^ 165)};
  endfunction
  // one clock; pins change just after the rising edge so the sampler never races
  task automatic step(input logic l, input logic f, input logic d, input logic [23:0] x);
    #6 cl_clk = 1'b1;
    cl_lval <= l;
    cl_fval <= f;
    cl_dval <= d;
    cl_data <= x;
    #6 cl_clk = 1'b0;
  endtask
  // clock runs only for frames and settle gaps; idle data keeps flipping
  task automatic idle(input int n);
    repeat (n) step(1'b0, 1'b0, 1'b0, ~cl_data);
  endtask
  // dvm: 0 active high, 1 inverted, 2 camera without a data-valid line (toggles)
  task automatic frame(input int nl, input int np, input int dvm, input logic fv);
    logic dv;
    for (int v = 0; v < nl; v++) begin
      repeat (2) step(1'b0, fv, dvm == 1, ~cl_data);
      for (int h = 0; h < np; h++) begin
        dv = (dvm == 2) ? ~cl_dval : (dvm == 0);
        step(1'b1, fv, dv, pix(v, h));
      end
    end
    repeat (2) step(1'b0, fv, dvm == 1, ~cl_data);
    step(1'b0, 1'b0, dvm == 1, ~cl_data);
  endtask
endmodule

// ===== test_camera_link_capture_control.sv
// self-checking bench for the capture control block
`timescale 1ns/1ps
module test_camera_link_capture_control;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [23:0] cl_data, pix_data;
  logic pready, pslverr, cl_clk, cl_lval, cl_fval, cl_dval, pix_valid, pix_eol, pix_eof, frame_valid;
  int fail_count = 0;
  int comparisons = 0;
  int eof_n = 0;
  int eol_n = 0;
  logic [23:0] got_q[$];
  logic [23:0] exp_q[$];

  clc_capture i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
                     .cl_clk, .cl_lval, .cl_fval, .cl_dval, .cl_data, .pix_valid, .pix_data, .pix_eol,
                     .pix_eof, .frame_valid);
  clc_cam_model i_cam (.cl_clk, .cl_lval, .cl_fval, .cl_dval, .cl_data);

  // register clock, 4 ns period
  always #2 pclk = ~pclk;

  // collect output words, line and frame ends mid-cycle, where the registered outputs stand
  always @(negedge cl_clk) begin
    if (pix_valid === 1'b1) got_q.push_back(pix_data);
    if (pix_eof === 1'b1) eof_n++;
    if (pix_eol === 1'b1) eol_n++;
  end

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    check(r, exp, "register read");
    check({31'h0, e}, {31'h0, err}, "slave error");
  endtask

  // program the block, send one frame, compare words against a model built here
  task automatic run(input logic [7:0] lk, input logic [7:0] ut, input logic [7:0] pa, input int hs,
                     input int ha, input int vs, input int va, input int nl, input int np, input int dvm,
                     input logic fv, input int eofs);
    logic cd, pad, full;
    logic [23:0] m, x;
    int nb, seen, neol;
    wr(12'h03c, {24'h0, ut});
    wr(12'h0a0, {24'h0, pa});
    wr(12'h0c0, 32'(hs));
    wr(12'h0c4, 32'(ha));
    wr(12'h0c8, 32'(vs));
    wr(12'h0cc, 32'(va));
    wr(12'h0a4, {24'h0, lk});
    // clock must run for the settings to reach the pixel domain
    i_cam.idle(30);
    cd = lk[3];
    pad = lk[7];
    full = cd && !pad;
    nb = lk[0] ? 24 : (int'(pa[7:4]) + 1) * (int'(pa[3:0]) + 1);
    m = (nb >= 24) ? 24'hffffff : 24'((32'h1 << nb) - 1);
    exp_q.delete();
    got_q.delete();
    eof_n = 0;
    eol_n = 0;
    neol = 0;
    for (int v = 0; v < nl; v++) begin
      seen = 0;
      if (cd || (v >= vs && v < vs + va)) begin
        neol++;
        for (int h = 0; h < np; h++) begin
          if (full || (h >= hs && h < hs + ha)) begin
            x = i_cam.pix(v, h) & m;
            exp_q.push_back(ut[0] ? {x[7:0], x[15:8], x[23:16]} : x);
            seen++;
          end
        end
        if (pad && !full && seen > 0) repeat (ha - seen) exp_q.push_back(24'h0);
      end
    end
    // missing lines of a short frame come back as zero words
    if (pad && !cd) begin
      for (int v = nl; v < vs + va; v++) begin
        if (v >= vs) begin
          repeat (ha) exp_q.push_back(24'h0);
          neol++;
        end
      end
    end
    i_cam.frame(nl, np, dvm, fv);
    i_cam.idle(8);
    check(got_q.size(), exp_q.size(), "word count");
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) check(got_q[i], exp_q[i], "pixel word");
    check(eof_n, eofs, "frame ends");
    check(eol_n, neol, "line ends");
  endtask

  // hang guard; the whole sequence needs well under this
  initial begin
    #200000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    fork
      i_cam.idle(20);
      begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
      end
    join
    i_cam.idle(4);
    rd_chk(12'h03c, 32'h00, 1'b0);
    rd_chk(12'h0a0, 32'h07, 1'b0);
    rd_chk(12'h0a4, 32'h00, 1'b0);
    rd_chk(12'h000, 32'h00, 1'b1);
    wr(12'h0a4, 32'hff);
    rd_chk(12'h0a4, 32'hbf, 1'b0);
    run(8'h09, 8'h00, 8'h19, 0, 0, 0, 0, 2, 4, 0, 1'b1, 1);
    run(8'h09, 8'h01, 8'h19, 0, 0, 0, 0, 2, 4, 0, 1'b1, 1);
    run(8'h01, 8'h00, 8'h07, 1, 2, 1, 1, 3, 4, 0, 1'b1, 1);
    run(8'h08, 8'h00, 8'h19, 0, 0, 0, 0, 2, 3, 0, 1'b1, 1);
    rd_chk(12'h0a0, 32'h19, 1'b0);
    run(8'h29, 8'h00, 8'h07, 0, 0, 0, 0, 2, 3, 1, 1'b1, 1);
    run(8'h0b, 8'h00, 8'h07, 0, 0, 0, 0, 2, 3, 2, 1'b1, 1);
    run(8'h0d, 8'h00, 8'h07, 0, 0, 0, 0, 3, 2, 0, 1'b0, 3);
    run(8'h1d, 8'h00, 8'h07, 0, 0, 0, 2, 4, 2, 0, 1'b0, 2);
    run(8'h81, 8'h00, 8'h07, 0, 4, 0, 2, 1, 4, 0, 1'b1, 1);
    run(8'h89, 8'h00, 8'h07, 0, 4, 0, 1, 2, 3, 0, 1'b1, 1);
    run(8'h00, 8'h00, 8'h07, 0, 4, 0, 1, 1, 3, 0, 1'b1, 1);
    // let the measured size cross back before reading it
    i_cam.idle(8);
    rd_chk(12'h0d0, 32'h0001_0003, 1'b0);
    finish_test();
  end
endmodule
